// File: hdl/sspe_exec.sv
// Purpose: Executes stack pops, pushes and user-stack pops.
// Assumes: Register file and stack memory answer reads in the next cycle.
// Notes: Flags are never touched; busy stalls the issuing stage.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: POP reads byte at SP, writes destination, then increments SP.
// RULE2: No stack transfer instruction alters any condition flag.
// RULE3: User stack pointer is a register holding the stack top address.
// RULE4: Opcode 92 copies top into destination, then decrements pointer.
// RULE5: Opcode 93 copies top into destination, then increments pointer.
// RULE6: PUSH decrements SP first, then writes source at new SP.
// RULE7: SP is one 16-bit value; decrement from zero wraps to all ones.
// RULE8: Indirect POP writes to the register addressed by named register.
// RULE9: User stack pointer updates wrap modulo 256 silently.
module sspe_exec (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire sspe_pkg::sspe_instr_type instr,
  output logic instr_ready,
  output logic busy,
  output logic illegal_opcode,
  output logic [7:0] rf_rd_addr,
  output logic rf_rd_en,
  input wire logic [7:0] rf_rd_data,
  output logic rf_wr_en,
  output sspe_pkg::sspe_wr_type rf_wr,
  output logic [15:0] stk_addr,
  output logic stk_rd_en,
  input wire logic [7:0] stk_rd_data,
  output logic stk_wr_en,
  output logic [7:0] stk_wr_data,
  output logic flags_write_en,
  output logic [7:0] stack_pointer_high_byte,
  output logic [7:0] stack_pointer_low_byte
);

  sspe_pkg::sspe_state_type state_r, state_nxt;
  sspe_pkg::sspe_instr_type ins_r, ins_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic [7:0] indirect_register_operand_r, indirect_register_operand_nxt;
  logic illegal_r, illegal_nxt;
  logic sp_inc;
  logic sp_dec;
  logic is_legal;

  sspe_sp_reg u_sp (
    .clk(clk),
    .reset_n(reset_n),
    .inc(sp_inc),
    .dec(sp_dec),
    .stack_pointer_high_byte(stack_pointer_high_byte),
    .stack_pointer_low_byte(stack_pointer_low_byte)
  );

  // RULE2: flags untouched. No path in this block ever writes a flag.
  assign flags_write_en = 1'b0;
  assign instr_ready = (state_r == sspe_pkg::ST_IDLE);
  assign busy = !instr_ready;
  assign illegal_opcode = illegal_r;
  assign stk_addr = {stack_pointer_high_byte, stack_pointer_low_byte};

  // Opcodes this block owns; anything else is refused with a pulse.
  always_comb begin
    case (instr.opcode)
      sspe_pkg::OPC_POP_DIRECT,
      sspe_pkg::OPC_POP_INDIRECT,
      sspe_pkg::OPC_PUSH_DIRECT,
      sspe_pkg::OPC_PUSH_INDIRECT,
      sspe_pkg::OPC_USER_POP_DOWN,
      sspe_pkg::OPC_USER_POP_UP: is_legal = 1'b1;
      default: is_legal = 1'b0;
    endcase
  end

  // Sequencer: at most one register-file and one stack access per state keeps ports simple.
  always_comb begin
    state_nxt = state_r;
    ins_nxt = ins_r;
    byte_nxt = byte_r;
    indirect_register_operand_nxt = indirect_register_operand_r;
    illegal_nxt = 1'b0;
    sp_inc = 1'b0;
    sp_dec = 1'b0;
    rf_rd_en = 1'b0;
    rf_rd_addr = sspe_pkg::BYTE_ZERO;
    rf_wr_en = 1'b0;
    rf_wr = '0;
    stk_rd_en = 1'b0;
    stk_wr_en = 1'b0;
    stk_wr_data = byte_r;
    case (state_r)
      sspe_pkg::ST_IDLE: begin
        if (instr_valid) begin
          ins_nxt = instr;
          illegal_nxt = !is_legal;
          if (!is_legal) begin
            state_nxt = sspe_pkg::ST_IDLE;
          end else if (instr.opcode == sspe_pkg::OPC_POP_DIRECT ||
                       instr.opcode == sspe_pkg::OPC_POP_INDIRECT) begin
            state_nxt = sspe_pkg::ST_RD_DATA;
          end else begin
            state_nxt = sspe_pkg::ST_RD_PTR;
          end
        end
      end
      sspe_pkg::ST_RD_PTR: begin
        // RULE3: pointer in regfile. User pointer or push source fetched.
        rf_rd_en = 1'b1;
        if (ins_r.opcode == sspe_pkg::OPC_PUSH_DIRECT ||
            ins_r.opcode == sspe_pkg::OPC_PUSH_INDIRECT) begin
          rf_rd_addr = ins_r.dst;
          state_nxt = sspe_pkg::ST_WR_STACK;
          if (ins_r.opcode == sspe_pkg::OPC_PUSH_INDIRECT) begin
            state_nxt = sspe_pkg::ST_RD_IND;
          end
        end else begin
          rf_rd_addr = ins_r.src;
          state_nxt = sspe_pkg::ST_RD_DATA;
        end
      end
      sspe_pkg::ST_RD_IND: begin
        // Second level of indirection for the indirect push source.
        rf_rd_en = 1'b1;
        rf_rd_addr = rf_rd_data;
        state_nxt = sspe_pkg::ST_WR_STACK;
      end
      sspe_pkg::ST_RD_DATA: begin
        if (ins_r.opcode == sspe_pkg::OPC_POP_DIRECT ||
            ins_r.opcode == sspe_pkg::OPC_POP_INDIRECT) begin
          // RULE1: read at SP. The stack byte is fetched before any update.
          stk_rd_en = 1'b1;
          if (ins_r.opcode == sspe_pkg::OPC_POP_INDIRECT) begin
            rf_rd_en = 1'b1;
            rf_rd_addr = ins_r.dst;
          end
        end else begin
          // RULE3: indirect source. The top is read through the pointer.
          indirect_register_operand_nxt = rf_rd_data;
          rf_rd_en = 1'b1;
          rf_rd_addr = rf_rd_data;
        end
        state_nxt = sspe_pkg::ST_WR_DST;
      end
      sspe_pkg::ST_WR_DST: begin
        rf_wr_en = 1'b1;
        if (ins_r.opcode == sspe_pkg::OPC_POP_DIRECT) begin
          rf_wr.addr = ins_r.dst;
          rf_wr.data = stk_rd_data;
          // RULE1: then increment. SP moves only after the byte is used.
          sp_inc = 1'b1;
          state_nxt = sspe_pkg::ST_IDLE;
        end else if (ins_r.opcode == sspe_pkg::OPC_POP_INDIRECT) begin
          // RULE8: indirect destination. Write goes where the register points.
          rf_wr.addr = rf_rd_data;
          rf_wr.data = stk_rd_data;
          sp_inc = 1'b1;
          state_nxt = sspe_pkg::ST_IDLE;
        end else begin
          // RULE4: copy top. Both user pops land in the named register.
          rf_wr.addr = ins_r.dst;
          rf_wr.data = rf_rd_data;
          state_nxt = sspe_pkg::ST_WR_PTR;
        end
      end
      sspe_pkg::ST_WR_PTR: begin
        rf_wr_en = 1'b1;
        rf_wr.addr = ins_r.src;
        // RULE9: silent byte wrap. 8-bit arithmetic drops the carry.
        if (ins_r.opcode == sspe_pkg::OPC_USER_POP_UP) begin
          // RULE5: pointer increment.
          rf_wr.data = indirect_register_operand_r + sspe_pkg::BYTE_ONE;
        end else begin
          // RULE4: pointer decrement.
          rf_wr.data = indirect_register_operand_r - sspe_pkg::BYTE_ONE;
        end
        state_nxt = sspe_pkg::ST_IDLE;
      end
      sspe_pkg::ST_WR_STACK: begin
        // RULE6: decrement first. The byte is held while SP settles.
        byte_nxt = rf_rd_data;
        sp_dec = 1'b1;
        state_nxt = sspe_pkg::ST_RD_DATA;
        ins_nxt.opcode = sspe_pkg::BYTE_ZERO;
      end
      default: begin
        state_nxt = sspe_pkg::ST_IDLE;
      end
    endcase
    // RULE6: write at new SP. Marked by the cleared opcode after decrement.
    if (state_r == sspe_pkg::ST_RD_DATA &&
        ins_r.opcode == sspe_pkg::BYTE_ZERO) begin
      stk_rd_en = 1'b0;
      rf_rd_en = 1'b0;
      rf_rd_addr = sspe_pkg::BYTE_ZERO;
      indirect_register_operand_nxt = indirect_register_operand_r;
      stk_wr_en = 1'b1;
      state_nxt = sspe_pkg::ST_IDLE;
    end
  end

  // State registers.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= sspe_pkg::ST_IDLE;
      ins_r <= '0;
      byte_r <= sspe_pkg::BYTE_ZERO;
      indirect_register_operand_r <= sspe_pkg::BYTE_ZERO;
      illegal_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ins_r <= ins_nxt;
      byte_r <= byte_nxt;
      indirect_register_operand_r <= indirect_register_operand_nxt;
      illegal_r <= illegal_nxt;
    end
  end

endmodule
`default_nettype wire

// File: hdl/sspe_pkg.sv
// Purpose: Shared constants and carrier types for the stack transfer unit.
// Assumes: 8-bit register file, 16-bit system stack pointer.
// Notes: Opcodes, widths and the state encodings live here.
package sspe_pkg;

  localparam logic [7:0] OPC_POP_DIRECT = 8'h50;
  localparam logic [7:0] OPC_POP_INDIRECT = 8'h51;
  localparam logic [7:0] OPC_PUSH_DIRECT = 8'h70;
  localparam logic [7:0] OPC_PUSH_INDIRECT = 8'h71;
  localparam logic [7:0] OPC_USER_POP_DOWN = 8'h92;
  localparam logic [7:0] OPC_USER_POP_UP = 8'h93;
  localparam int DATA_W = 8;
  localparam int SP_W = 16;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] SP_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // One decoded instruction as handed in by the fetch stage.
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] dst;
    logic [7:0] src;
  } sspe_instr_type;

  // One register-file write request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } sspe_wr_type;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_RD_PTR = 7'b0000010,
    ST_RD_DATA = 7'b0000100,
    ST_WR_DST = 7'b0001000,
    ST_WR_PTR = 7'b0010000,
    ST_RD_IND = 7'b0100000,
    ST_WR_STACK = 7'b1000000
  } sspe_state_type;

endpackage

// File: hdl/sspe_sp_reg.sv
// Purpose: The 16-bit system stack pointer built from its two bytes.
// Assumes: Only one of increment and decrement is asked for at a time.
// Notes: Wraps modulo 65536 in both directions.
`timescale 1ns/1ps
`default_nettype none
module sspe_sp_reg (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic inc,
  input wire logic dec,
  output logic [7:0] stack_pointer_high_byte,
  output logic [7:0] stack_pointer_low_byte
);

  logic [15:0] sp_r;
  logic [15:0] sp_nxt;

  // RULE7: sixteen-bit wrap. Plain 16-bit arithmetic carries between bytes.
  always_comb begin
    sp_nxt = sp_r;
    if (inc) begin
      sp_nxt = sp_r + sspe_pkg::SP_ONE;
    end else if (dec) begin
      sp_nxt = sp_r - sspe_pkg::SP_ONE;
    end
  end

  // Pointer register.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sp_r <= sspe_pkg::SP_RESET;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  assign stack_pointer_high_byte = sp_r[15:8];
  assign stack_pointer_low_byte = sp_r[7:0];

endmodule
`default_nettype wire

// File: sim/sspe_chk.sv
// Purpose: Port checks for the stack transfer unit.
// Assumes: Reads are answered one cycle after the request.
// Notes: Offsets count from the edge that takes the instruction.
`timescale 1ns/1ps
`default_nettype none
module sspe_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire sspe_pkg::sspe_instr_type instr,
  input wire logic instr_ready,
  input wire logic [7:0] rf_rd_addr,
  input wire logic rf_rd_en,
  input wire logic [7:0] rf_rd_data,
  input wire logic rf_wr_en,
  input wire sspe_pkg::sspe_wr_type rf_wr,
  input wire logic [15:0] stk_addr,
  input wire logic stk_rd_en,
  input wire logic [7:0] stk_rd_data,
  input wire logic stk_wr_en,
  input wire logic flags_write_en,
  input wire logic [7:0] stack_pointer_high_byte,
  input wire logic [7:0] stack_pointer_low_byte
);
  logic [15:0] sp;
  logic [7:0] op;
  logic tk;
  // The pointer is judged as one word, so a lost carry shows.
  assign sp = {stack_pointer_high_byte, stack_pointer_low_byte};
  assign tk = instr_valid && instr_ready;
  assign op = instr.opcode;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Each check but flags_kept_a ties an output to the inputs seen at the take edge.
  flags_kept_a: assert property (!flags_write_en)
    else $error("flag write seen");
  pop_order_a: assert property (
    tk && op == 8'h50 |-> ##1 stk_rd_en && stk_addr == $past(sp)
    ##1 rf_wr_en && rf_wr.data == stk_rd_data &&
    rf_wr.addr == $past(instr.dst, 2) ##1 sp == $past(sp, 3) + 16'h0001)
    else $error("pop wrong");
  // The pointer register itself must be read before its contents are used.
  pop_indirect_a: assert property (
    tk && op == 8'h51 |-> ##1 rf_rd_en && rf_rd_addr == $past(instr.dst)
    ##1 rf_wr_en && rf_wr.addr == rf_rd_data && rf_wr.data == stk_rd_data)
    else $error("indirect pop target wrong");
  push_dir_a: assert property (
    tk && op == 8'h70 |-> ##3 stk_wr_en && stk_addr == sp &&
    sp == $past(sp, 3) - 16'h0001)
    else $error("push wrong");
  push_ind_a: assert property (
    tk && op == 8'h71 |-> ##4 stk_wr_en && sp == $past(sp, 4) - 16'h0001)
    else $error("indirect push wrong");
  uptr_read_a: assert property (
    tk && op inside {8'h92, 8'h93} |-> ##1 rf_rd_en &&
    rf_rd_addr == $past(instr.src) ##1 rf_rd_en && rf_rd_addr == rf_rd_data)
    else $error("user pointer not used as address");
  upop_down_a: assert property (
    tk && op == 8'h92 |-> ##3 rf_wr_en && rf_wr.addr == $past(instr.dst, 3)
    ##1 rf_wr_en && rf_wr.data == $past(rf_rd_data, 2) - 8'h01)
    else $error("pop down wrong");
  upop_up_a: assert property (
    tk && op == 8'h93 |-> ##4 rf_wr_en && rf_wr.addr == $past(instr.src, 4)
    && rf_wr.data == $past(rf_rd_data, 2) + 8'h01)
    else $error("pop up wrong");
  cover property (tk && op == 8'h50);
  cover property (tk && op == 8'h92);
  cover property (tk && op == 8'h71);
endmodule
bind sspe_exec sspe_chk i_chk (.clk, .reset_n, .instr_valid, .instr,
  .instr_ready, .rf_rd_addr, .rf_rd_en, .rf_rd_data, .rf_wr_en, .rf_wr,
  .stk_addr, .stk_rd_en, .stk_rd_data, .stk_wr_en, .flags_write_en,
  .stack_pointer_high_byte, .stack_pointer_low_byte);
`default_nettype wire

// File: sim/sspe_mem.sv
// Purpose: Register file and stack memory facing the stack unit.
// Assumes: Reads return data one cycle after the request.
// Notes: Idle read lines show the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none
module sspe_mem (
  input wire logic clk,
  input wire logic [7:0] rf_rd_addr,
  input wire logic rf_rd_en,
  output logic [7:0] rf_rd_data,
  input wire logic rf_wr_en,
  input wire sspe_pkg::sspe_wr_type rf_wr,
  input wire logic [15:0] stk_addr,
  input wire logic stk_rd_en,
  output logic [7:0] stk_rd_data,
  input wire logic stk_wr_en,
  input wire logic [7:0] stk_wr_data
);
  logic [7:0] rf [256];
  logic [7:0] stk [65536];
  // Inverting idle data keeps a stale byte from passing for a fresh one.
  always @(posedge clk) begin
    rf_rd_data <= rf_rd_en ? rf[rf_rd_addr] : ~rf_rd_data;
    stk_rd_data <= stk_rd_en ? stk[stk_addr] : ~stk_rd_data;
    if (rf_wr_en) rf[rf_wr.addr] <= rf_wr.data;
    if (stk_wr_en) stk[stk_addr] <= stk_wr_data;
  end
endmodule
`default_nettype wire

// File: sim/stack_push_pop_exec_tb_top.sv
// Purpose: Self-checking bench for the stack transfer unit.
// Assumes: The memory model answers reads in the next cycle.
// Notes: Scenarios chain; each starts from the pointer left before.
`timescale 1ns/1ps
`default_nettype none
module stack_push_pop_exec_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic instr_valid = 1'b0;
  sspe_pkg::sspe_instr_type instr = '0;
  logic instr_ready, busy, illegal_opcode, rf_rd_en, rf_wr_en;
  logic stk_rd_en, stk_wr_en, flags_write_en;
  logic [7:0] rf_rd_addr, rf_rd_data, stk_rd_data, stk_wr_data;
  logic [7:0] stack_pointer_high_byte, stack_pointer_low_byte;
  logic [15:0] stk_addr, sp;
  sspe_pkg::sspe_wr_type rf_wr;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  assign sp = {stack_pointer_high_byte, stack_pointer_low_byte};
  // A 4 ns clock.
  always #2 clk = ~clk;
  sspe_exec i_dut (.clk, .reset_n, .instr_valid, .instr, .instr_ready,
    .busy, .illegal_opcode, .rf_rd_addr, .rf_rd_en, .rf_rd_data,
    .rf_wr_en, .rf_wr, .stk_addr, .stk_rd_en, .stk_rd_data, .stk_wr_en,
    .stk_wr_data, .flags_write_en, .stack_pointer_high_byte,
    .stack_pointer_low_byte);
  sspe_mem i_mem (.clk, .rf_rd_addr, .rf_rd_en, .rf_rd_data, .rf_wr_en,
    .rf_wr, .stk_addr, .stk_rd_en, .stk_rd_data, .stk_wr_en, .stk_wr_data);
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // A hang stops here; all scenarios need well under a hundred cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 300) begin
      mismatches++;
      close_out;
    end
  end
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Holds the request through the taking edge, then waits for ready.
  task automatic run(input logic [7:0] op, input logic [7:0] d,
                     input logic [7:0] s);
    instr_valid <= 1'b1;
    instr <= {op, d, s};
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    for (int i = 0; i < 20 && instr_ready !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
  endtask
  // Pushes from zero wrap the pointer to the top of memory.
  task automatic t_push;
    run(8'h70, 8'h40, 8'h00);
    chk(16'hFFFF, sp);
    chk(16'h004F, {8'h00, i_mem.stk[16'hFFFF]});
    run(8'h71, 8'h40, 8'h00);
    chk(16'h00AA, {8'h00, i_mem.stk[16'hFFFE]});
    chk(16'hFFFE, sp);
  endtask
  // Back-to-back pops, the second through a pointer register.
  task automatic t_pop;
    run(8'h50, 8'h00, 8'h00);
    chk(16'h00AA, {8'h00, i_mem.rf[0]});
    chk(16'hFFFF, sp);
    run(8'h51, 8'h01, 8'h00);
    chk(16'h004F, {8'h00, i_mem.rf[8'h10]});
    chk(16'h0010, {8'h00, i_mem.rf[1]});
    chk(16'h0000, sp);
  endtask
  // User pops at both pointer boundaries wrap silently.
  task automatic t_user;
    run(8'h92, 8'h02, 8'h05);
    chk(16'h00AA, {8'h00, i_mem.rf[2]});
    chk(16'h00FF, {8'h00, i_mem.rf[5]});
    run(8'h93, 8'h03, 8'h05);
    chk(16'h0070, {8'h00, i_mem.rf[3]});
    chk(16'h0000, {8'h00, i_mem.rf[5]});
    chk(16'h0000, sp);
    chk(16'h0000, {15'h0000, flags_write_en});
  endtask
  // An unknown opcode only pulses its flag; a legal one right after is busy.
  // The pulse stands for one cycle, so it is judged at the following negedge.
  task automatic t_illegal;
    instr_valid <= 1'b1;
    instr <= {8'hFF, 8'h04, 8'h05};
    @(posedge clk);
    instr <= {8'h93, 8'h04, 8'h05};
    @(negedge clk);
    chk(16'h0001, {15'h0000, illegal_opcode});
    chk(16'h0000, {15'h0000, busy});
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    chk(16'h0000, {15'h0000, illegal_opcode});
    chk(16'h0001, {15'h0000, busy});
    for (int i = 0; i < 20 && instr_ready !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    chk(16'h00AA, {8'h00, i_mem.rf[4]});
    chk(16'h0001, {8'h00, i_mem.rf[5]});
    chk(16'h0000, sp);
  endtask
  // Preload operands, reset for two cycles, then run the scenarios.
  initial begin
    i_mem.rf[8'h40] = 8'h4F;
    i_mem.rf[8'h4F] = 8'hAA;
    i_mem.rf[8'h01] = 8'h10;
    i_mem.rf[8'h05] = 8'h00;
    i_mem.rf[8'hFF] = 8'h70;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_push;
    t_pop;
    t_user;
    t_illegal;
    close_out;
  end
endmodule
`default_nettype wire
